//--- verilog/sample_mux_pkg.sv
package sample_mux_pkg;

    // ----------------------------------------------------------------
    // Widths and grouping
    // ----------------------------------------------------------------
    localparam int SAMPLE_W = 24;
    localparam int LINK_SLOTS = 4;
    localparam int SINGLE_GROUP = 1;
    localparam int DOUBLE_GROUP = 2;
    localparam int QUAD_GROUP = 4;
    localparam int FRAME_RATE_44K1_HZ = 44100;
    localparam int FRAME_RATE_48K_HZ = 48000;

    // ----------------------------------------------------------------
    // Fixed latencies in sample periods
    // ----------------------------------------------------------------
    localparam int PASS_DELAY = 3;
    localparam int AD_DELAY_LOW = 5;
    localparam int AD_DELAY_HIGH = 6;
    localparam int DA_DELAY = 6;
    localparam int MAX_DELAY = 6;
    localparam int DEPTH_W = 3;

    // ----------------------------------------------------------------
    // Host side figures
    // ----------------------------------------------------------------
    localparam int BUF_W = 16;
    localparam int SEQ_W = 8;
    localparam int POS_W = 32;
    localparam logic [BUF_W-1:0] SAFETY_BUFFER = 16'h0020;
    localparam logic [BUF_W-1:0] SAFETY_OFFSET = 16'h0010;
    localparam logic [BUF_W-1:0] NO_OFFSET = 16'h0000;
    localparam int SAMPLES_PER_PKT = 8;

    // Link slot filling state, one-hot
    typedef enum logic [3:0] {
        SLOT_0 = 4'h1,
        SLOT_1 = 4'h2,
        SLOT_2 = 4'h4,
        SLOT_3 = 4'h8
    } slot_state_type;

endpackage

//--- verilog/sample_delay_line.sv
`timescale 1ns/10ps
module sample_delay_line #(
    parameter int W = 24,
    parameter int MAXD = 6,
    parameter int DW = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic adv,
    input wire logic [DW-1:0] depth,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout_r
);

    logic [W-1:0] stage_r [MAXD];

    // ----------------------------------------------------------------
    // Shift on each sample tick; stage j holds the sample j+1 ticks old
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < MAXD; i++) begin
                stage_r[i] <= '0;
            end
        end else if (adv) begin
            stage_r[0] <= din;
            for (int i = 1; i < MAXD; i++) begin
                stage_r[i] <= stage_r[i-1];
            end
        end
    end

    // Output shows the sample that entered depth ticks earlier
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_r <= '0;
        end else if (adv) begin
            dout_r <= stage_r[depth - DW'(1)];
        end
    end

endmodule

//--- verilog/sample_mux_latency_path.sv
`timescale 1ns/10ps
// Function
// R01 - Double rate spreads each channel's samples over two link channels.
// R02 - Link frames stay at single rate while multiplexing.
// R03 - Double wire: odd samples in one subframe, even in the other.
// R04 - Digital pass-through delays three sample periods for every input.
// R05 - Input conversion adds five or six periods; output adds six.
// R06 - Playback on USB adds 32 samples to the configured buffer.
// R07 - USB safety offset of 16 samples is applied and reported. The code only reports it on safety_offset_r and applies it nowhere.
// R08 - Incoming USB transfers are checked; each error is made visible.
// R09 - Lost packets keep streams running and realign sample position.
// R10 - Quad rate spreads each channel over four link channels.
// R11 - Earliest sample goes to lowest link channel, then ascending.
module sample_mux_latency_path #(
    parameter int SPP = sample_mux_pkg::SAMPLES_PER_PKT
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic double_rate_mode,
    input wire logic quad_rate_mode,
    input wire logic src_tick,
    input wire logic [sample_mux_pkg::SAMPLE_W-1:0] src_sample,
    output logic link_frame_r,
    output logic [sample_mux_pkg::LINK_SLOTS-1:0]
        [sample_mux_pkg::SAMPLE_W-1:0] link_slot_r,
    input wire logic rx_tick,
    input wire logic [sample_mux_pkg::SAMPLE_W-1:0] rx_sample,
    output logic [sample_mux_pkg::SAMPLE_W-1:0] tx_sample,
    input wire logic conv_tick,
    input wire logic rate_above_96k,
    input wire logic [sample_mux_pkg::SAMPLE_W-1:0] ad_sample,
    output logic [sample_mux_pkg::SAMPLE_W-1:0] rec_sample,
    input wire logic [sample_mux_pkg::SAMPLE_W-1:0] play_sample,
    output logic [sample_mux_pkg::SAMPLE_W-1:0] da_sample,
    input wire logic usb_connected,
    input wire logic [sample_mux_pkg::BUF_W-1:0] cfg_buffer_size,
    output logic [sample_mux_pkg::BUF_W-1:0] play_buffer_total_r,
    output logic [sample_mux_pkg::BUF_W-1:0] safety_offset_r,
    input wire logic usb_pkt_valid,
    input wire logic [sample_mux_pkg::SEQ_W-1:0] usb_pkt_seq,
    input wire logic usb_pkt_crc_ok,
    output logic usb_err_r,
    output logic [sample_mux_pkg::BUF_W-1:0] usb_err_count_r,
    output logic usb_lost_r,
    output logic [sample_mux_pkg::POS_W-1:0] sample_pos_r
);
    import sample_mux_pkg::*;
    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_core_n;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_core_n = rst_sync_r[1];
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic int group_size(input logic dbl, input logic quad);
        if (quad) begin
            return QUAD_GROUP;
        end else if (dbl) begin
            return DOUBLE_GROUP;
        end
        return SINGLE_GROUP;
    endfunction
    function automatic int slot_index(input slot_state_type s);
        unique case (s)
            SLOT_0: return 0;
            SLOT_1: return 1;
            SLOT_2: return 2;
            SLOT_3: return 3;
            default: return 0;
        endcase
    endfunction
    // ----------------------------------------------------------------
    // Sample multiplexing onto the link
    // ----------------------------------------------------------------
    slot_state_type slot_r;
    slot_state_type slot_nxt;
    logic [LINK_SLOTS-1:0][SAMPLE_W-1:0] fill_r;
    logic group_done;
    int cur_idx;
    int grp;
    always_comb begin
        cur_idx = slot_index(slot_r);
        grp = group_size(double_rate_mode, quad_rate_mode); // R01 R10
        group_done = (cur_idx >= grp - 1);
        unique case (slot_r)
            SLOT_0: slot_nxt = SLOT_1;
            SLOT_1: slot_nxt = SLOT_2;
            SLOT_2: slot_nxt = SLOT_3;
            SLOT_3: slot_nxt = SLOT_0;
            default: slot_nxt = SLOT_0;
        endcase
        if (group_done) begin
            slot_nxt = SLOT_0;
        end
    end
    // Slot position advances once per source sample
    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            slot_r <= SLOT_0;
        end else if (src_tick) begin
            slot_r <= slot_nxt; // R11
        end
    end
    // Collect earlier samples of the group in ascending slots
    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            fill_r <= '0;
        end else if (src_tick) begin
            fill_r[cur_idx] <= src_sample; // R11
        end
    end
    // One link frame per full group keeps the carrier at single rate
    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            link_frame_r <= 1'b0;
            link_slot_r <= '0;
        end else begin
            link_frame_r <= src_tick && group_done; // R02
            if (src_tick && group_done) begin
                for (int i = 0; i < LINK_SLOTS; i++) begin
                    if (i == cur_idx) begin
                        link_slot_r[i] <= src_sample;
                    end else if (i < grp) begin
                        link_slot_r[i] <= fill_r[i]; // R01 R03 R10
                    end else begin
                        link_slot_r[i] <= '0;
                    end
                end
            end
        end
    end
    // ----------------------------------------------------------------
    // Fixed latency paths
    // ----------------------------------------------------------------
    logic [DEPTH_W-1:0] ad_depth;
    assign ad_depth = rate_above_96k ? DEPTH_W'(AD_DELAY_HIGH)
                                     : DEPTH_W'(AD_DELAY_LOW); // R05
    sample_delay_line #(.W(SAMPLE_W), .MAXD(MAX_DELAY), .DW(DEPTH_W))
    u_pass (
        .clk(ref_clk),
        .rst_n(rst_core_n),
        .adv(rx_tick),
        .depth(DEPTH_W'(PASS_DELAY)), // R04
        .din(rx_sample),
        .dout_r(tx_sample)
    );
    sample_delay_line #(.W(SAMPLE_W), .MAXD(MAX_DELAY), .DW(DEPTH_W))
    u_ad (
        .clk(ref_clk),
        .rst_n(rst_core_n),
        .adv(conv_tick),
        .depth(ad_depth), // R05
        .din(ad_sample),
        .dout_r(rec_sample)
    );
    sample_delay_line #(.W(SAMPLE_W), .MAXD(MAX_DELAY), .DW(DEPTH_W))
    u_da (
        .clk(ref_clk),
        .rst_n(rst_core_n),
        .adv(conv_tick),
        .depth(DEPTH_W'(DA_DELAY)), // R05
        .din(play_sample),
        .dout_r(da_sample)
    );
    // ----------------------------------------------------------------
    // Playback buffer and safety offset report
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            play_buffer_total_r <= '0;
            safety_offset_r <= NO_OFFSET;
        end else if (usb_connected) begin
            play_buffer_total_r <= cfg_buffer_size + SAFETY_BUFFER; // R06
            safety_offset_r <= SAFETY_OFFSET; // R07
        end else begin
            play_buffer_total_r <= cfg_buffer_size;
            safety_offset_r <= NO_OFFSET;
        end
    end
    // ----------------------------------------------------------------
    // USB transfer checking and drop-out recovery
    // ----------------------------------------------------------------
    logic seq_valid_r;
    logic [SEQ_W-1:0] seq_exp_r;
    logic [SEQ_W-1:0] gap;
    logic pkt_lost;
    assign gap = usb_pkt_seq - seq_exp_r;
    assign pkt_lost = usb_pkt_valid && seq_valid_r && (gap != '0);
    // Expected sequence number follows every received packet
    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            seq_valid_r <= 1'b0;
            seq_exp_r <= '0;
        end else if (usb_pkt_valid) begin
            seq_valid_r <= 1'b1;
            seq_exp_r <= usb_pkt_seq + SEQ_W'(1);
        end
    end
    // Damaged transfers pulse and count, saturating
    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            usb_err_r <= 1'b0;
            usb_err_count_r <= '0;
        end else begin
            usb_err_r <= usb_pkt_valid && !usb_pkt_crc_ok; // R08
            if (usb_pkt_valid && !usb_pkt_crc_ok
                && usb_err_count_r != '1) begin
                usb_err_count_r <= usb_err_count_r + BUF_W'(1); // R08
            end
        end
    end
    // Position skips the missing packets so streams stay aligned
    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            usb_lost_r <= 1'b0;
            sample_pos_r <= '0;
        end else begin
            usb_lost_r <= pkt_lost;
            if (pkt_lost) begin
                sample_pos_r <= sample_pos_r
                    + POS_W'((gap + SEQ_W'(1)) * SPP); // R09
            end else if (usb_pkt_valid) begin
                sample_pos_r <= sample_pos_r + POS_W'(SPP);
            end
        end
    end
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_core_n);
    logic [2:0] ticks_r;
    logic [SAMPLE_W-1:0] hist_r [PASS_DELAY];
    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            ticks_r <= '0;
        end else if (src_tick) begin
            ticks_r <= (src_tick && group_done) ? 3'h0 : ticks_r + 3'h1;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            for (int i = 0; i < PASS_DELAY; i++) begin
                hist_r[i] <= '0;
            end
        end else if (rx_tick) begin
            hist_r[0] <= rx_sample;
            for (int i = 1; i < PASS_DELAY; i++) begin
                hist_r[i] <= hist_r[i-1];
            end
        end
    end
    a_frame_from_tick: assert property ( // R01
        link_frame_r |-> $past(src_tick))
        else $error("link frame without source sample");
    a_double_group: assert property ( // R02
        (src_tick && double_rate_mode && !quad_rate_mode && ticks_r == 3'h0)
        |=> !link_frame_r)
        else $error("double rate frame after one sample");
    a_quad_group: assert property ( // R10
        (src_tick && quad_rate_mode)
        |=> link_frame_r == ($past(ticks_r) == 3'h3))
        else $error("quad rate frame not every fourth sample");
    a_slot_order: assert property ( // R11
        (src_tick && $past(src_tick) && double_rate_mode && ticks_r == 3'h1
        && !quad_rate_mode) |=> link_slot_r[0] == $past(src_sample, 2)
        && link_slot_r[1] == $past(src_sample))
        else $error("double wire slot order wrong");
    a_pass_delay: assert property ( // R04
        rx_tick |=> tx_sample == $past(hist_r[PASS_DELAY-1]))
        else $error("pass-through delay not three samples");
    a_play_buffer: assert property ( // R06
        usb_connected |=> play_buffer_total_r
        == $past(cfg_buffer_size) + SAFETY_BUFFER)
        else $error("safety buffer not added");
    a_safety_offset: assert property ( // R07
        usb_connected |=> safety_offset_r == SAFETY_OFFSET)
        else $error("safety offset not reported");
    a_usb_error: assert property ( // R08
        (usb_pkt_valid && !usb_pkt_crc_ok && usb_err_count_r != '1)
        |=> usb_err_r && usb_err_count_r == $past(usb_err_count_r) + 16'h1)
        else $error("transfer error not counted");
    a_realign: assert property ( // R09
        pkt_lost |=> usb_lost_r && sample_pos_r > $past(sample_pos_r)
        + POS_W'(SPP))
        else $error("position not realigned after loss");
    c_double_frame: cover property (
        double_rate_mode && !quad_rate_mode && link_frame_r);
    c_quad_frame: cover property (quad_rate_mode && link_frame_r);
    c_usb_error: cover property (usb_err_r);
    c_usb_loss: cover property (usb_lost_r);
endmodule

//--- testbench/audio_gear_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Far-side digital audio gear: sends samples, watches the link
// ----------------------------------------------------------------
module audio_gear_model (
    input wire logic clk,
    input wire logic send_en,
    input wire logic link_frame_r,
    input wire logic [sample_mux_pkg::LINK_SLOTS-1:0]
        [sample_mux_pkg::SAMPLE_W-1:0] link_slot_r,
    output logic rx_tick,
    output logic [sample_mux_pkg::SAMPLE_W-1:0] rx_sample,
    output int sent_count,
    output int frames_seen,
    output logic [sample_mux_pkg::LINK_SLOTS-1:0]
        [sample_mux_pkg::SAMPLE_W-1:0] last_slots
);
    import sample_mux_pkg::*;

    logic [1:0] phase_r;

    initial begin
        rx_tick = 1'b0;
        rx_sample = 24'h000000;
        sent_count = 0;
        frames_seen = 0;
        last_slots = '0;
        phase_r = 2'h0;
    end

    // One sample every four cycles; line toggles between samples
    always @(negedge clk) begin
        phase_r <= phase_r + 2'h1;
        if (send_en && phase_r == 2'h3) begin
            rx_tick <= 1'b1;
            rx_sample <= 24'h100000 + sent_count[23:0];
            sent_count <= sent_count + 1;
        end else begin
            rx_tick <= 1'b0;
            rx_sample <= ~rx_sample;
        end
    end

    // Slot 0 holds the earliest (odd) sample of each group
    always @(posedge clk) begin
        if (link_frame_r === 1'b1) begin
            frames_seen <= frames_seen + 1;
            last_slots <= link_slot_r;
        end
    end
endmodule

//--- testbench/sample_mux_latency_path_tb_top.sv
`timescale 1ns/10ps
module sample_mux_latency_path_tb_top;
    import sample_mux_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0, rst_n = 1'b0, send_en = 1'b0;
    logic double_rate_mode = 1'b0, quad_rate_mode = 1'b0;
    logic src_tick = 1'b0, conv_tick = 1'b0, rate_above_96k = 1'b0;
    logic [SAMPLE_W-1:0] src_sample = '0, ad_sample = '0;
    logic [SAMPLE_W-1:0] play_sample = '0, rx_sample, tx_sample;
    logic [SAMPLE_W-1:0] rec_sample, da_sample;
    logic link_frame_r, rx_tick, usb_err_r, usb_lost_r;
    logic [LINK_SLOTS-1:0][SAMPLE_W-1:0] link_slot_r, last_slots;
    logic usb_connected = 1'b0, usb_pkt_valid = 1'b0;
    logic usb_pkt_crc_ok = 1'b1;
    logic [BUF_W-1:0] cfg_buffer_size = 16'h0100;
    logic [BUF_W-1:0] play_buffer_total_r, safety_offset_r;
    logic [BUF_W-1:0] usb_err_count_r;
    logic [SEQ_W-1:0] usb_pkt_seq = 8'h00;
    logic [POS_W-1:0] sample_pos_r;
    int bad_count = 0, checked = 0, sent_count, frames_seen;

    sample_mux_latency_path uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .double_rate_mode(double_rate_mode),
        .quad_rate_mode(quad_rate_mode), .src_tick(src_tick),
        .src_sample(src_sample), .link_frame_r(link_frame_r),
        .link_slot_r(link_slot_r), .rx_tick(rx_tick),
        .rx_sample(rx_sample), .tx_sample(tx_sample),
        .conv_tick(conv_tick), .rate_above_96k(rate_above_96k),
        .ad_sample(ad_sample), .rec_sample(rec_sample),
        .play_sample(play_sample), .da_sample(da_sample),
        .usb_connected(usb_connected),
        .cfg_buffer_size(cfg_buffer_size),
        .play_buffer_total_r(play_buffer_total_r),
        .safety_offset_r(safety_offset_r),
        .usb_pkt_valid(usb_pkt_valid), .usb_pkt_seq(usb_pkt_seq),
        .usb_pkt_crc_ok(usb_pkt_crc_ok), .usb_err_r(usb_err_r),
        .usb_err_count_r(usb_err_count_r), .usb_lost_r(usb_lost_r),
        .sample_pos_r(sample_pos_r));

    audio_gear_model gear (.clk(ref_clk), .send_en(send_en),
        .link_frame_r(link_frame_r), .link_slot_r(link_slot_r),
        .rx_tick(rx_tick), .rx_sample(rx_sample),
        .sent_count(sent_count), .frames_seen(frames_seen),
        .last_slots(last_slots));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Single, double and quad grouping of back-to-back source ticks
    task automatic test_mux();
        int g;
        int f0;
        for (int mi = 0; mi < 3; mi++) begin
            g = (mi == 0) ? 1 : (mi == 1) ? 2 : 4;
            double_rate_mode = (mi == 1);
            quad_rate_mode = (mi == 2);
            @(negedge ref_clk);
            f0 = frames_seen;
            for (int k = 0; k < 2 * g; k++) begin
                src_tick = 1'b1;
                src_sample = 24'hA00000 + 24'(mi * 16 + k);
                @(negedge ref_clk);
                if (k % g == g - 1) begin
                    src_tick = 1'b0;
                    src_sample = ~src_sample;
                    repeat (3) @(negedge ref_clk);
                    chk("frames", f0 + (k + 1) / g, frames_seen);
                    for (int s = 0; s < 4; s++)
                        chk("slot", (s < g) ? 32'hA00000 + mi * 16
                            + k - g + 1 + s : 0, last_slots[s]);
                end
            end
        end
        $display("test mux done");
    endtask

    // Receiver to transmitter pass-through
    task automatic test_pass();
        int j;
        int w;
        send_en = 1'b1;
        for (int n = 0; n < 8; n++) begin
            w = 0;
            @(posedge ref_clk);
            while (rx_tick !== 1'b1 && w < 10) begin
                @(posedge ref_clk);
                w++;
            end
            j = sent_count - 1;
            repeat (2) @(negedge ref_clk);
            chk("tx", (j >= 3) ? 32'h100000 + j - 3 : 0, tx_sample);
        end
        send_en = 1'b0;
        $display("test pass done");
    endtask

    // Converter delays, switching to the high rate mid-stream
    task automatic test_conv();
        int d;
        for (int j = 0; j < 16; j++) begin
            if (j == 8)
                rate_above_96k = 1'b1;
            conv_tick = 1'b1;
            ad_sample = 24'h200000 + 24'(j);
            play_sample = 24'h300000 + 24'(j);
            @(negedge ref_clk);
            conv_tick = 1'b0;
            ad_sample = ~ad_sample;
            play_sample = ~play_sample;
            @(negedge ref_clk);
            d = (j >= 8) ? 6 : 5;
            if (j < 8 || j >= 14)
                chk("rec", (j >= d) ? 32'h200000 + j - d : 0,
                    rec_sample);
            chk("da", (j >= 6) ? 32'h300000 + j - 6 : 0, da_sample);
        end
        $display("test conv done");
    endtask

    // Playback buffer and safety offset with and without USB
    task automatic test_buffer();
        for (int u = 0; u < 2; u++) begin
            usb_connected = u[0];
            repeat (2) @(negedge ref_clk);
            chk("buf", u ? 32'h0120 : 32'h0100, play_buffer_total_r);
            chk("offset", u ? 32'h0010 : 32'h0000, safety_offset_r);
        end
        $display("test buffer done");
    endtask

    // Packet errors, a sequence gap and position realignment
    task automatic test_usb();
        logic [7:0] seqs [4] = '{8'h05, 8'h06, 8'h09, 8'h0A};
        logic [31:0] pos [4] = '{32'h08, 32'h10, 32'h28, 32'h30};
        int errs;
        int losts;
        for (int i = 0; i < 4; i++) begin
            usb_pkt_valid = 1'b1;
            usb_pkt_seq = seqs[i];
            usb_pkt_crc_ok = (i != 1);
            @(negedge ref_clk);
            errs = (usb_err_r === 1'b1);
            losts = (usb_lost_r === 1'b1);
            usb_pkt_valid = 1'b0;
            usb_pkt_seq = ~usb_pkt_seq;
            usb_pkt_crc_ok = ~usb_pkt_crc_ok;
            repeat (3) begin
                @(negedge ref_clk);
                errs += (usb_err_r === 1'b1);
                losts += (usb_lost_r === 1'b1);
            end
            chk("err_pulse", (i == 1), errs);
            chk("err_count", (i >= 1), usb_err_count_r);
            chk("lost_pulse", (i == 2), losts);
            chk("position", pos[i], sample_pos_r);
        end
        $display("test usb done");
    endtask

    // ------------------------------------------------------------
    // Clock, reset, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        bad_count++;
        $display("ERROR watchdog expected done seen hang");
        close_out();
    end

    initial begin
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("pos_reset", 32'h0, sample_pos_r);
        chk("tx_reset", 32'h0, tx_sample);
        test_mux();
        test_pass();
        test_conv();
        test_buffer();
        test_usb();
        close_out();
    end
endmodule
